/* File: rtl/gain_apply.v */
// raw gain to linear factor, applied to luma with saturation
`timescale 1ns/1ns
`default_nettype none
`include "pix_map.vh"
module gain_apply (
  // clock and reset
  input  wire       hclk,
  input  wire       hresetn,
  input  wire       ce,
  // luma in with its raw gain
  input  wire       in_valid,
  input  wire [7:0] in_y,
  input  wire [9:0] in_gain,
  // scaled out
  output reg        out_valid_q,
  output reg  [7:0] out_q
);
  wire [18:0] expo;   // log2 of factor, q16
  wire [8:0]  mant;   // 1 + fraction, q8; linear approx of 2^frac
  wire [16:0] prod;   // luma times mantissa
  wire [19:0] shft;   // after integer octaves
  wire [11:0] res;    // result before saturation

  // 0.0359 db per count equals raw * 0.005966 octaves
  assign expo = in_gain * `GAIN_LOG2_K;
  assign mant = {1'b1, expo[15:8]};
  assign prod = in_y * mant;
  assign shft = {3'b000, prod} << expo[18:16];
  assign res  = shft[19:8];

  // more gain never lowers output up to raw 670 (shift 3), above that shft can wrap; clipped at the 8-bit ceiling
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_valid_q <= 1'b0;
      out_q       <= 8'h00;
    end else if (ce) begin
      out_valid_q <= in_valid;
      if (in_valid)
        out_q <= (res > 12'h0ff) ? 8'hff : res[7:0];
    end
  end
endmodule // gain_apply
`default_nettype wire

/* File: rtl/luma_calc.v */
// luma from rgb, blended with the left neighbour pixel
`timescale 1ns/1ns
`default_nettype none
module luma_calc (
  // clock and reset
  input  wire       hclk,
  input  wire       hresetn,
  input  wire       ce,
  // pixel in
  input  wire       in_valid,
  input  wire       in_row_start,
  input  wire [7:0] in_r,
  input  wire [7:0] in_g,
  input  wire [7:0] in_b,
  // luma out
  output reg        y_valid_q,
  output reg  [7:0] y_q
);
  reg [7:0] prev_q;   // luma of the left neighbour
  wire [7:0] y_self;  // luma of this pixel alone
  wire [8:0] y_sum;   // pixel plus neighbour

  // bt.601 weights, sum of weights is 256 so no overflow
  function [7:0] luma;
    input [7:0] r;
    input [7:0] g;
    input [7:0] b;
    reg [15:0] acc;
    begin
      acc  = 16'd77 * r + 16'd150 * g + 16'd29 * b;
      luma = acc[15:8];
    end
  endfunction

  assign y_self = luma(in_r, in_g, in_b);
  // first column has no left neighbour, so it blends with itself
  assign y_sum  = {1'b0, y_self} + {1'b0, (in_row_start ? y_self : prev_q)};

  // one byte per accepted pixel, one cycle latency
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q    <= 8'h00;
      y_q       <= 8'h00;
      y_valid_q <= 1'b0;
    end else if (ce) begin
      y_valid_q <= in_valid;
      if (in_valid) begin
        prev_q <= y_self;
        y_q    <= y_sum[8:1];
      end
    end
  end
endmodule // luma_calc
`default_nettype wire

/* File: rtl/mono_pixel_output.v */
// mono 8 pixel output with per-quadrant gain, ahb-lite register slave
//
// Chosen here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "pix_map.vh"
module mono_pixel_output (
  // clock, reset, enable
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        ce,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [31:0] hrdata,
  // colour pixel stream from the sensor pipeline
  input  wire        frame_start,
  input  wire        pix_valid,
  input  wire [7:0]  pix_r,
  input  wire [7:0]  pix_g,
  input  wire [7:0]  pix_b,
  output reg         pix_ready,
  // gain from the automatic function
  input  wire [9:0]  auto_gain,
  // mono byte stream to the transmit path
  output reg         out_valid,
  output reg  [7:0]  out_data,
  output reg         out_first,
  output reg         out_last
);
  // registers
  reg  [1:0]  ctrl_q;        // four-channel select, auto gain enable
  reg  [2:0]  gain_sel_q;    // target selector
  reg  [9:0]  gain_all_q;    // global gain
  reg  [9:0]  trim_q [0:3];  // quadrant trims, top-left first
  reg  [11:0] frame_w_q;     // columns per row
  reg  [11:0] frame_h_q;     // rows per frame
  // bus data phase
  reg         wr_pend_q;     // write data phase pending
  reg         rd_pend_q;     // read data phase pending
  reg  [7:0]  addr_q;        // latched word address
  // frame position
  reg  [11:0] col_q;         // column of next input pixel
  reg  [11:0] row_q;         // row of next input pixel
  reg  [1:0]  div_q;         // one-channel pacing counter
  // pipeline side band
  reg  [9:0]  gain_p1_q;     // gain aligned with luma stage
  reg         first_p1_q;    // first pixel marker, stage 1
  reg         last_p1_q;     // last pixel marker, stage 1
  reg         first_p2_q;    // first pixel marker, stage 2
  reg         last_p2_q;     // last pixel marker, stage 2

  wire        four_ch;       // four-channel readout active
  wire        auto_on;       // automatic gain active
  wire        addr_ok;       // valid address phase seen
  wire        accept;        // pixel taken this cycle
  wire        col_end;       // last column of the row
  wire        row_end;       // last row of the frame
  wire [1:0]  quad;          // quadrant of the incoming pixel
  wire [9:0]  gain_glb;      // global gain in force
  wire [10:0] gain_sum;      // global plus trim
  wire [9:0]  gain_px;       // gain for the incoming pixel
  wire [9:0]  wr_val;        // clamped write value
  wire        y_valid;       // luma stage output valid
  wire [7:0]  y_val;         // luma stage output
  wire        g_valid;       // gain stage output valid
  wire [7:0]  g_val;         // gain stage output
  reg  [31:0] rd_mux;        // read data for latched address

  // clamp a signed 32-bit write to 0 .. 600
  function [9:0] clamp_gain;
    input [31:0] v;
    begin
      if (v[31])
        clamp_gain = 10'h000;
      else if (v > {22'h000000, `GAIN_MAX})
        clamp_gain = `GAIN_MAX;
      else
        clamp_gain = v[9:0];
    end
  endfunction

  // selector code to trim index, used on write and read
  function [1:0] trim_idx;
    input [2:0] sel;
    begin
      trim_idx = sel[1:0] - 2'h1;
    end
  endfunction

  // selector points at a trim that is visible in this mode
  function is_trim;
    input [2:0] sel;
    input       four;
    begin
      is_trim = four && (sel >= `SEL_TRIM1) && (sel <= `SEL_TRIM4);
    end
  endfunction

  assign four_ch  = ctrl_q[`CTRL_FOUR_BIT];
  assign auto_on  = ctrl_q[`CTRL_AUTO_BIT];
  assign addr_ok  = hsel && hready && htrans[1];
  assign wr_val   = clamp_gain(hwdata);
  // auto gain overrides the global value while enabled
  assign gain_glb = auto_on ? auto_gain : gain_all_q;
  // quadrant from position: bit1 bottom half, bit0 right half
  assign quad     = {(row_q >= {1'b0, frame_h_q[11:1]}), (col_q >= {1'b0, frame_w_q[11:1]})};
  assign gain_sum = {1'b0, gain_glb} + {1'b0, trim_q[quad]};
  // sum saturates in case software broke the combined limit
  assign gain_px  = !four_ch ? gain_glb :
                    (gain_sum > {1'b0, `GAIN_MAX}) ? `GAIN_MAX : gain_sum[9:0];
  assign accept   = pix_valid && pix_ready;
  assign col_end  = (col_q == frame_w_q - 12'h001);
  assign row_end  = (row_q == frame_h_q - 12'h001);

  // register read mux
  always @* begin
    rd_mux = 32'h00000000;
    case (addr_q)
      `OFS_CTRL:     rd_mux = {30'h00000000, ctrl_q};
      `OFS_GAIN_SEL: rd_mux = {29'h00000000, gain_sel_q};
      `OFS_GAIN_RAW: rd_mux = {22'h000000,
                               is_trim(gain_sel_q, four_ch) ? trim_q[trim_idx(gain_sel_q)] : gain_all_q};
      `OFS_FRAME_W:  rd_mux = {20'h00000, frame_w_q};
      `OFS_FRAME_H:  rd_mux = {20'h00000, frame_h_q};
      `OFS_STATUS:   rd_mux = {4'h0, row_q, 4'h0, col_q};
      default:       rd_mux = 32'h00000000;
    endcase
  end

  // ahb address phase capture; reads take one wait state
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
    end else if (ce) begin
      hresp <= 1'b0;
      if (rd_pend_q) begin
        // wait state over: data valid while hreadyout is high
        rd_pend_q <= 1'b0;
        hreadyout <= 1'b1;
        hrdata    <= rd_mux;
      end else begin
        wr_pend_q <= addr_ok && hwrite;
        rd_pend_q <= addr_ok && !hwrite;
        hreadyout <= !(addr_ok && !hwrite);
        if (addr_ok)
          addr_q <= {haddr[7:2], 2'b00};
      end
    end
  end

  // register writes in the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q     <= `CTRL_RESET;
      gain_sel_q <= `SEL_GLOBAL;
      gain_all_q <= `GAIN_RESET;
      trim_q[0]  <= `GAIN_RESET;
      trim_q[1]  <= `GAIN_RESET;
      trim_q[2]  <= `GAIN_RESET;
      trim_q[3]  <= `GAIN_RESET;
      frame_w_q  <= `FRAME_W_RESET;
      frame_h_q  <= `FRAME_H_RESET;
    end else if (ce && wr_pend_q) begin
      case (addr_q)
        `OFS_CTRL:     ctrl_q <= hwdata[1:0];
        `OFS_GAIN_SEL: gain_sel_q <= (hwdata[2:0] > `SEL_TRIM4) ? `SEL_TRIM4 : hwdata[2:0];
        `OFS_GAIN_RAW: begin
          // selector routes the value; trims hidden in one-channel mode
          if (is_trim(gain_sel_q, four_ch))
            trim_q[trim_idx(gain_sel_q)] <= wr_val;
          else if (gain_sel_q == `SEL_GLOBAL)
            gain_all_q <= wr_val;
        end
        // zero geometry would stall the counters, keep at least one
        `OFS_FRAME_W:  frame_w_q <= (hwdata[11:0] == 12'h000) ? 12'h001 : hwdata[11:0];
        `OFS_FRAME_H:  frame_h_q <= (hwdata[11:0] == 12'h000) ? 12'h001 : hwdata[11:0];
        default:       ctrl_q <= ctrl_q;
      endcase
    end
  end

  // pacing: one-channel readout takes a pixel every fourth cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q     <= 2'h0;
      pix_ready <= 1'b0;
    end else if (ce) begin
      div_q     <= (div_q == `ONE_CH_DIV) ? 2'h0 : div_q + 2'h1;
      pix_ready <= four_ch || (div_q == `ONE_CH_DIV);
    end
  end

  // raster position, left to right then top to bottom
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      col_q <= 12'h000;
      row_q <= 12'h000;
    end else if (ce) begin
      if (frame_start) begin
        col_q <= 12'h000;
        row_q <= 12'h000;
      end else if (accept) begin
        col_q <= col_end ? 12'h000 : col_q + 12'h001;
        if (col_end)
          row_q <= row_end ? 12'h000 : row_q + 12'h001;
      end
    end
  end

  // side band travels alongside the two pipeline stages
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gain_p1_q  <= 10'h000;
      first_p1_q <= 1'b0;
      last_p1_q  <= 1'b0;
      first_p2_q <= 1'b0;
      last_p2_q  <= 1'b0;
    end else if (ce) begin
      if (accept) begin
        gain_p1_q  <= gain_px;
        first_p1_q <= (col_q == 12'h000) && (row_q == 12'h000) && !frame_start;
        last_p1_q  <= col_end && row_end && !frame_start;
      end
      if (y_valid) begin
        first_p2_q <= first_p1_q;
        last_p2_q  <= last_p1_q;
      end
    end
  end

  // luma stage: colour to one brightness byte
  luma_calc u_luma (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .ce           (ce),
    .in_valid     (accept),
    .in_row_start (frame_start || col_q == 12'h000),
    .in_r         (pix_r),
    .in_g         (pix_g),
    .in_b         (pix_b),
    .y_valid_q    (y_valid),
    .y_q          (y_val)
  );

  // gain stage: quadrant gain applied to luma
  gain_apply u_gain (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .ce          (ce),
    .in_valid    (y_valid),
    .in_y        (y_val),
    .in_gain     (gain_p1_q),
    .out_valid_q (g_valid),
    .out_q       (g_val)
  );

  // output register: one unsigned byte per pixel in raster order
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_valid <= 1'b0;
      out_data  <= 8'h00;
      out_first <= 1'b0;
      out_last  <= 1'b0;
    end else if (ce) begin
      out_valid <= g_valid;
      out_first <= g_valid && first_p2_q;
      out_last  <= g_valid && last_p2_q;
      if (g_valid)
        out_data <= g_val;
    end
  end
endmodule // mono_pixel_output
`default_nettype wire

/* File: rtl/pix_map.vh */
// register offsets, field positions, reset values and limits of the mono pixel block
`ifndef PIX_MAP_VH
`define PIX_MAP_VH
// register byte offsets
`define OFS_CTRL        8'h00
`define OFS_GAIN_SEL    8'h04
`define OFS_GAIN_RAW    8'h08
`define OFS_FRAME_W     8'h0c
`define OFS_FRAME_H     8'h10
`define OFS_STATUS      8'h14
// control fields
`define CTRL_FOUR_BIT   0
`define CTRL_AUTO_BIT   1
`define CTRL_RESET      2'h1
// selector codes
`define SEL_GLOBAL      3'h0
`define SEL_TRIM1       3'h1
`define SEL_TRIM4       3'h4
// gain limits and resets
`define GAIN_MAX        10'h258
`define GAIN_RESET      10'h000
// frame geometry resets
`define FRAME_W_RESET   12'h280
`define FRAME_H_RESET   12'h1e0
// status fields
`define STAT_COL_LSB    0
`define STAT_ROW_LSB    16
// gain to linear factor: log2 step per raw count, q16 (0.0359 db per count)
`define GAIN_LOG2_K     9'h187
// single-channel pacing counter wraps at this value, so one pixel is accepted every fourth cycle
`define ONE_CH_DIV      2'h3
`endif

/* File: verification/host_buf.sv */
// host image buffer model collecting the transmitted luma bytes
`timescale 1ns/1ns
`default_nettype none
module host_buf (
  // clock
  input wire logic       hclk,
  // byte stream from the block
  input wire logic       out_valid,
  input wire logic [7:0] out_data,
  input wire logic       out_first,
  input wire logic       out_last
);
  logic [7:0] bytes_q[$]; // byte k of the current frame
  logic       done_q = 1'b0; // last byte of a frame arrived
  // a first byte restarts at position 0, so a missing flag shows as excess bytes
  always @(posedge hclk) begin
    if (out_valid) begin
      if (out_first) begin
        bytes_q.delete();
      end
      bytes_q.push_back(out_data);
      done_q <= out_last;
    end
  end
endmodule // host_buf
`default_nettype wire

/* File: verification/mono_pixel_output_chk.sv */
// port-level assertions for the mono pixel output block
`timescale 1ns/1ns
`default_nettype none
module mono_pixel_output_chk (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        ce,
  // register bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // pixel in and byte out
  input wire logic        pix_valid,
  input wire logic        pix_ready,
  input wire logic        out_valid,
  input wire logic        out_first,
  input wire logic        out_last
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire  req  = hsel && hready && htrans[1] && ce; // bus request taken
  wire  take = pix_valid && pix_ready && ce;      // pixel taken
  logic wr_ctrl_q;                                 // ctrl write in data phase
  logic four_q;                                    // shadow of the mode bit
  // shadow the mode bit here, as the checker sees only the ports
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ctrl_q <= 1'b0;
      four_q    <= 1'b1;
    end else begin
      wr_ctrl_q <= req && hwrite && haddr[7:2] == 6'h00;
      if (wr_ctrl_q) begin
        four_q <= hwdata[0];
      end
    end
  end
  sequence rd_req;
    req && !hwrite;
  endsequence
  sequence one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  rd_wait_a: assert property (rd_req |=> one_wait)
    else $error("read wait state wrong");
  wr_nowait_a: assert property (req && hwrite |=> hreadyout)
    else $error("write was stalled");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  byte_lat_a: assert property (take |-> ##3 out_valid)
    else $error("pixel gave no byte");
  byte_src_a: assert property (out_valid |-> $past(take, 3))
    else $error("byte without pixel");
  first_qual_a: assert property (out_first |-> out_valid)
    else $error("first flag without byte");
  last_qual_a: assert property (out_last |-> out_valid)
    else $error("last flag without byte");
  // looks backwards so a mode write landing mid-window cannot trip it
  one_rate_a: assert property (pix_ready && !$past(four_q, 1) && !$past(four_q, 2) &&
    !$past(four_q, 3) && !$past(four_q, 4) |-> !$past(pix_ready, 1) && !$past(pix_ready, 2) &&
    !$past(pix_ready, 3))
    else $error("single channel too fast");
endmodule // mono_pixel_output_chk
bind mono_pixel_output mono_pixel_output_chk chk_i (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hreadyout, .hresp, .pix_valid, .pix_ready, .out_valid, .out_first, .out_last);
`default_nettype wire

/* File: verification/mono_pixel_output_tb_top.sv */
// self-checking bench for the mono pixel output block
`timescale 1ns/1ns
`default_nettype none
`include "pix_map.vh"
module mono_pixel_output_tb_top;
  typedef logic [7:0] px_t [8];
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  logic        hclk = 1'b0;      // 50 mhz clock
  logic        hresetn = 1'b0;   // held low at start
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic        frame_start = 1'b0;
  logic        pix_valid = 1'b0;
  logic [7:0]  pix_r = 8'h0;
  logic [7:0]  pix_g = 8'h0;
  logic [7:0]  pix_b = 8'h0;
  logic [9:0]  auto_gain = 10'h0;
  wire logic   hreadyout, hresp, pix_ready, out_valid, out_first, out_last;
  wire logic [31:0] hrdata;
  wire logic [7:0]  out_data;
  int          fail_count = 0;
  int          checks = 0;
  row_t        rows[15];          // register cases
  logic [31:0] rd;                // last read data
  always #10 hclk = ~hclk;
  // ce held high: freezing is not part of the documented behaviour
  mono_pixel_output uut (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .frame_start, .pix_valid, .pix_r, .pix_g, .pix_b,
    .pix_ready, .auto_gain, .out_valid, .out_data, .out_first, .out_last);
  host_buf sink (.hclk, .out_valid, .out_data, .out_first, .out_last);
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task tmo;
    fail_count++;
    $display("[FAIL] wait expected done seen timeout");
    wrap_up;
  endtask
  // wait for hready high at a rising edge, bounded
  task hwait;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) tmo;
  endtask
  // one single ahb-lite word transfer; entered just after a rising edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    hwait;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hwait;
    r = hrdata;
  endtask
  // send a 4x2 gray frame and compare the host buffer byte by byte
  task frame(input px_t pv, input px_t ex);
    int n;
    frame_start <= 1'b1;
    @(posedge hclk);
    frame_start <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      pix_r <= pv[i];
      pix_g <= pv[i];
      pix_b <= pv[i];
      pix_valid <= 1'b1;
      n = 0;
      do begin
        @(posedge hclk);
        n++;
      end while (pix_ready !== 1'b1 && n < 50);
      if (pix_ready !== 1'b1) tmo;
    end
    pix_valid <= 1'b0;
    n = 0;
    while (sink.done_q !== 1'b1 && n < 50) begin
      @(posedge hclk);
      n++;
    end
    if (sink.done_q !== 1'b1) tmo;
    chk("byte count", 32'h8, sink.bytes_q.size());
    for (int i = 0; i < 8; i++) begin
      chk($sformatf("byte %0d", i), {24'h0, ex[i]}, {24'h0, sink.bytes_q[i]});
    end
  endtask
  initial begin
    // access kind, offset, write data, expected read-back
    rows = '{'{1'b0, `OFS_CTRL, 32'h0, 32'h1}, '{1'b0, `OFS_GAIN_SEL, 32'h0, 32'h0},
      '{1'b0, `OFS_GAIN_RAW, 32'h0, 32'h0}, '{1'b0, `OFS_FRAME_W, 32'h0, `FRAME_W_RESET},
      '{1'b0, `OFS_FRAME_H, 32'h0, `FRAME_H_RESET}, '{1'b1, 8'h20, 32'h5, 32'h0},
      '{1'b1, `OFS_GAIN_SEL, 32'h7, 32'h4}, '{1'b1, `OFS_GAIN_RAW, 32'h2bc, 32'h258},
      '{1'b1, `OFS_GAIN_SEL, 32'h1, 32'h1}, '{1'b1, `OFS_GAIN_RAW, 32'h80000123, 32'h0},
      '{1'b1, `OFS_GAIN_SEL, 32'h0, 32'h0}, '{1'b1, `OFS_GAIN_RAW, 32'h258, 32'h258},
      '{1'b1, `OFS_GAIN_RAW, 32'h0, 32'h0}, '{1'b1, `OFS_FRAME_W, 32'h4, 32'h4},
      '{1'b1, `OFS_FRAME_H, 32'h2, 32'h2}};
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) bus(1'b1, rows[i].a, rows[i].d, rd);
      bus(1'b0, rows[i].a, 32'h0, rd);
      chk($sformatf("reg %h", rows[i].a), rows[i].e, rd);
    end
    $display("test registers done");
    // ramp: left-neighbour blend, trim 4 at max saturates bottom right only
    // global 0 with trims in range keeps every quadrant sum legal
    frame('{8'h0a, 8'h14, 8'h28, 8'h50, 8'h00, 8'h02, 8'hfe, 8'hfe},
      '{8'h0a, 8'h0f, 8'h1e, 8'h3c, 8'h00, 8'h01, 8'hff, 8'hff});
    $display("test ramp frame done");
    // auto gain of 168 counts, about 6 db, doubles the level over the zero manual global
    auto_gain <= 10'h0a8;
    bus(1'b1, `OFS_CTRL, 32'h3, rd);
    frame('{default: 8'h64}, '{8'hc8, 8'hc8, 8'hc8, 8'hc8, 8'hc8, 8'hc8, 8'hff, 8'hff});
    bus(1'b1, `OFS_CTRL, 32'h1, rd);
    frame('{default: 8'h64}, '{8'h64, 8'h64, 8'h64, 8'h64, 8'h64, 8'h64, 8'hff, 8'hff});
    $display("test auto gain done");
    // single channel: trims neither written nor applied
    auto_gain <= 10'h0;
    bus(1'b1, `OFS_CTRL, 32'h0, rd);
    bus(1'b1, `OFS_GAIN_SEL, 32'h4, rd);
    bus(1'b1, `OFS_GAIN_RAW, 32'h9, rd);
    bus(1'b0, `OFS_GAIN_RAW, 32'h0, rd);
    chk("raw single channel", 32'h0, rd);
    frame('{default: 8'h64}, '{default: 8'h64});
    // back in four channels the refused write left trim 4 at its limit
    bus(1'b1, `OFS_CTRL, 32'h1, rd);
    bus(1'b0, `OFS_GAIN_RAW, 32'h0, rd);
    chk("raw trim 4 kept", 32'h258, rd);
    $display("test single channel done");
    // reset in mid-run restores four channels with auto off
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, `OFS_CTRL, 32'h0, rd);
    chk("ctrl after reset", 32'h1, rd);
    $display("test reset done");
    wrap_up;
  end
endmodule // mono_pixel_output_tb_top
`default_nettype wire
